// File: hw/arr_pkg.sv
// Purpose: shared constants and types for the converter ratio and ramp register bank
// Assumes: word index of a register sits on wishbone address bits [17:2]
// Notes: all registers are 16 bits wide in the low half of the bus word
package arr_pkg;

	localparam int NUM_CONV = 8;
	localparam int RATE_W = 20;
	localparam int REG_W = 16;
	localparam int LIMIT_W = 11;
	localparam int FRAC_BITS = 12;
	localparam int INT_BITS = 4;
	localparam int DIVIDEND_W = RATE_W + FRAC_BITS;
	localparam int STEP_W = 6;
	localparam logic [STEP_W-1:0] LAST_STEP = 6'(DIVIDEND_W - 1);
	localparam int BLOCK_SIZE = 4;

	// word indices; byte address is four times the index
	localparam int ADR_IDX_LSB = 2;
	localparam int ADR_IDX_MSB = 17;
	localparam logic [15:0] IDX_RATIO_BASE = 16'hf582;
	localparam logic [15:0] IDX_RATIO_LAST = 16'hf589;
	localparam logic [15:0] IDX_OVR = 16'hf590;
	localparam logic [15:0] IDX_LIMIT_BASE = 16'hf591;
	localparam logic [15:0] IDX_LIMIT_LAST = 16'hf598;
	localparam logic [15:0] IDX_MUTE_CTRL = 16'hf5b0;

	localparam logic [15:0] RATIO_RESET = 16'h0000;
	localparam logic [15:0] OVR_RESET = 16'h07ff;
	localparam logic [15:0] LIMIT_RESET = 16'h07ff;
	localparam logic [15:0] MUTE_RESET = 16'h0000;
	localparam logic [15:0] RATIO_SAT = 16'hffff;

	localparam int OVR_EN_BIT = 11;
	localparam int MUTE_LSB = 0;
	localparam int BLK0_DIS_BIT = 8;
	localparam int BLK1_DIS_BIT = 9;
	localparam logic [15:0] OVR_MASK = 16'h0fff;
	localparam logic [15:0] LIMIT_MASK = 16'h07ff;
	localparam logic [15:0] MUTE_MASK = 16'h03ff;

	typedef struct packed {
		logic [RATE_W-1:0] in_rate;
		logic [RATE_W-1:0] out_rate;
	} arr_rate_s;

	typedef struct packed {
		logic muted;
		logic [LIMIT_W-1:0] ramp_limit;
	} arr_conv_ctrl_s;

	typedef enum logic [2:0] {
		DIV_LOAD = 3'b001,
		DIV_RUN = 3'b010,
		DIV_STORE = 3'b100
	} arr_div_state_e;

endpackage

// File: hw/arr_regs.sv
// Purpose: ratio, ramp limit and mute register bank for eight rate converters
// Assumes: rate inputs come from logic on ref_clk_in; classic wishbone slave
// Notes: ratios are recomputed round robin by one shared serial divider
`timescale 1ns/1ps
`default_nettype none

module arr_regs
	import arr_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic clk_en_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [31:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire arr_rate_s [NUM_CONV-1:0] conv_rates_in,
	output arr_conv_ctrl_s [NUM_CONV-1:0] conv_ctrl_out
);

	// byte-lane merge used by every writable register
	function automatic logic [15:0] lane_merge(
		input logic [15:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0] sel,
		input logic [15:0] mask
	);
		logic [15:0] merged;
		merged = old_val;
		if (sel[0]) begin
			merged[7:0] = wdata[7:0];
		end
		if (sel[1]) begin
			merged[15:8] = wdata[15:8];
		end
		return merged & mask;
	endfunction

	// clamp the long quotient into the 16-bit 4.12 field
	function automatic logic [15:0] ratio_clamp(
		input logic [DIVIDEND_W-1:0] quot,
		input logic [RATE_W-1:0] divisor
	);
		logic [15:0] res;
		res = quot[15:0];
		if (divisor == '0) begin
			res = RATIO_RESET;
		end else if (quot[DIVIDEND_W-1:16] != '0) begin
			res = RATIO_SAT;
		end
		return res;
	endfunction

	// bus decode
	logic [15:0] idx;
	logic adr_hi_zero;
	logic req;
	logic wr_req;
	logic hit_ratio;
	logic hit_ovr;
	logic hit_limit;
	logic hit_mute;
	logic [2:0] ratio_sel;
	logic [2:0] limit_sel;
	logic [15:0] ratio_off;
	logic [15:0] limit_off;

	// register storage
	logic [15:0] ratio_reg [NUM_CONV];
	logic [15:0] limit_reg [NUM_CONV];
	logic [15:0] ovr_reg;
	logic [15:0] mute_ctrl_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [15:0] rdata_next;

	// divider
	arr_div_state_e div_state_reg;
	logic [2:0] chan_reg;
	logic [STEP_W-1:0] step_reg;
	logic [DIVIDEND_W-1:0] dividend_reg;
	logic [DIVIDEND_W-1:0] quot_reg;
	logic [RATE_W-1:0] divisor_reg;
	logic [RATE_W-1:0] rem_reg;
	logic [RATE_W:0] trial;
	logic [RATE_W:0] diff;
	logic qbit;

	assign idx = wb_adr_in[ADR_IDX_MSB:ADR_IDX_LSB];
	assign adr_hi_zero = (wb_adr_in[31:ADR_IDX_MSB+1] == '0);
	// ack_reg term keeps one access from being taken twice
	assign req = wb_cyc_in & wb_stb_in & ~ack_reg;
	assign wr_req = req & wb_we_in;

	assign ratio_off = idx - IDX_RATIO_BASE;
	assign limit_off = idx - IDX_LIMIT_BASE;
	assign ratio_sel = ratio_off[2:0];
	assign limit_sel = limit_off[2:0];

	assign hit_ratio = adr_hi_zero && (idx >= IDX_RATIO_BASE)
		&& (idx <= IDX_RATIO_LAST);
	assign hit_ovr = adr_hi_zero && (idx == IDX_OVR);
	assign hit_limit = adr_hi_zero && (idx >= IDX_LIMIT_BASE)
		&& (idx <= IDX_LIMIT_LAST);
	assign hit_mute = adr_hi_zero && (idx == IDX_MUTE_CTRL);

	// handshake: ack one cycle after the request, dropped the cycle after
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ack_reg <= 1'b0;
		end else if (clk_en_in) begin
			ack_reg <= req;
		end
	end

	assign wb_ack_out = ack_reg;

	// read mux; unmapped addresses answer zero
	always_comb begin
		rdata_next = 16'h0000;
		if (hit_ratio) begin
			rdata_next = ratio_reg[ratio_sel];
		end else if (hit_ovr) begin
			rdata_next = ovr_reg;
		end else if (hit_limit) begin
			rdata_next = limit_reg[limit_sel] & LIMIT_MASK;
		end else if (hit_mute) begin
			rdata_next = mute_ctrl_reg;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_reg <= 32'h0000_0000;
		end else if (clk_en_in && req) begin
			rdata_reg <= {16'h0000, rdata_next};
		end
	end

	assign wb_dat_out = rdata_reg;

	// override register
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ovr_reg <= OVR_RESET;
		end else if (clk_en_in && wr_req && hit_ovr) begin
			ovr_reg <= lane_merge(ovr_reg, wb_dat_in, wb_sel_in, OVR_MASK);
		end
	end

	// per-channel ramp limits; reserved bits never stored
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < NUM_CONV; i++) begin
				limit_reg[i] <= LIMIT_RESET;
			end
		end else if (clk_en_in && wr_req && hit_limit) begin
			limit_reg[limit_sel] <= lane_merge(limit_reg[limit_sel], wb_dat_in,
				wb_sel_in, LIMIT_MASK);
		end
	end

	// manual mutes and block mute disables
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mute_ctrl_reg <= MUTE_RESET;
		end else if (clk_en_in && wr_req && hit_mute) begin
			mute_ctrl_reg <= lane_merge(mute_ctrl_reg, wb_dat_in, wb_sel_in,
				MUTE_MASK);
		end
	end

	// converter control outputs
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			conv_ctrl_out <= '0;
		end else if (clk_en_in) begin
			for (int i = 0; i < NUM_CONV; i++) begin
				if (ovr_reg[OVR_EN_BIT]) begin
					conv_ctrl_out[i].ramp_limit <= ovr_reg[LIMIT_W-1:0];
				end else begin
					conv_ctrl_out[i].ramp_limit <= limit_reg[i][LIMIT_W-1:0];
				end
				if (i < BLOCK_SIZE) begin
					conv_ctrl_out[i].muted <= mute_ctrl_reg[MUTE_LSB + i]
						& ~mute_ctrl_reg[BLK0_DIS_BIT];
				end else begin
					conv_ctrl_out[i].muted <= mute_ctrl_reg[MUTE_LSB + i]
						& ~mute_ctrl_reg[BLK1_DIS_BIT];
				end
			end
		end
	end

	// restoring division step: shift in one dividend bit, try to subtract
	always_comb begin
		trial = {rem_reg, dividend_reg[DIVIDEND_W-1]};
		diff = trial - {1'b0, divisor_reg};
		qbit = (trial >= {1'b0, divisor_reg});
	end

	// one converter per pass; a pass takes the dividend width plus two cycles
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_state_reg <= DIV_LOAD;
			chan_reg <= 3'h0;
			step_reg <= '0;
			dividend_reg <= '0;
			divisor_reg <= '0;
			rem_reg <= '0;
			quot_reg <= '0;
		end else if (clk_en_in) begin
			unique case (div_state_reg)
				DIV_LOAD: begin
					// rates sampled once so a moving input cannot tear a result
					dividend_reg <= {conv_rates_in[chan_reg].in_rate,
						{FRAC_BITS{1'b0}}};
					divisor_reg <= conv_rates_in[chan_reg].out_rate;
					rem_reg <= '0;
					quot_reg <= '0;
					step_reg <= '0;
					div_state_reg <= DIV_RUN;
				end
				DIV_RUN: begin
					if (qbit) begin
						rem_reg <= diff[RATE_W-1:0];
					end else begin
						rem_reg <= trial[RATE_W-1:0];
					end
					quot_reg <= {quot_reg[DIVIDEND_W-2:0], qbit};
					dividend_reg <= {dividend_reg[DIVIDEND_W-2:0], 1'b0};
					step_reg <= step_reg + 6'h01;
					if (step_reg == LAST_STEP) begin
						div_state_reg <= DIV_STORE;
					end
				end
				DIV_STORE: begin
					chan_reg <= chan_reg + 3'h1;
					div_state_reg <= DIV_LOAD;
				end
				default: begin
					div_state_reg <= DIV_LOAD;
				end
			endcase
		end
	end

	// ratio results; zero output rate reads zero, overrange saturates
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < NUM_CONV; i++) begin
				ratio_reg[i] <= RATIO_RESET;
			end
		end else if (clk_en_in && div_state_reg == DIV_STORE) begin
			ratio_reg[chan_reg] <= ratio_clamp(quot_reg, divisor_reg);
		end
	end

endmodule

`default_nettype wire

// File: testbench/arr_regs_props.sv
// Purpose: bus and converter output checks for arr_regs
// Assumes: clock enable held high, sel lanes 0 and 1
// Notes: bound to every arr_regs instance
`timescale 1ns/1ps
`default_nettype none
module arr_regs_props
	import arr_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic clk_en_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [31:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	input wire arr_conv_ctrl_s [NUM_CONV-1:0] conv_ctrl_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	logic tk;
	logic wr;
	logic [15:0] ix;
	assign tk = wb_cyc_in & wb_stb_in & ~wb_ack_out & clk_en_in;
	assign wr = tk & wb_we_in & (wb_sel_in[1:0] == 2'b11);
	assign ix = wb_adr_in[17:2];
	chk_ack_due: assert property (tk |=> wb_ack_out)
		else $error("ack missing");
	chk_ack_single: assert property (wb_ack_out && clk_en_in |=> !wb_ack_out)
		else $error("ack too long");
	chk_data_hold: assert property ($changed(wb_dat_out) |-> $rose(wb_ack_out))
		else $error("read data moved");
	chk_upper_zero: assert property (wb_ack_out |-> wb_dat_out[31:16] == 16'h0000)
		else $error("upper half set");
	chk_limit_resv: assert property (tk && !wb_we_in && ix >= IDX_LIMIT_BASE &&
		ix <= IDX_LIMIT_LAST |=> wb_dat_out[15:11] == 5'h00) else $error("reserved set");
	chk_ovr_apply: assert property (wr && ix == IDX_OVR && wb_dat_in[OVR_EN_BIT] |=>
		##1 conv_ctrl_out[5].ramp_limit == $past(wb_dat_in[10:0], 2)) else $error("no override");
	chk_blk_dis: assert property (wr && ix == IDX_MUTE_CTRL && wb_dat_in[BLK0_DIS_BIT] |=>
		##1 !conv_ctrl_out[0].muted && !conv_ctrl_out[3].muted) else $error("block muted");
	chk_mute_set: assert property (wr && ix == IDX_MUTE_CTRL && wb_dat_in[5] &&
		!wb_dat_in[BLK1_DIS_BIT] |=> ##1 conv_ctrl_out[5].muted) else $error("not muted");
	cover property (wr && ix == IDX_OVR && wb_dat_in[OVR_EN_BIT]);
	cover property (wr && ix == IDX_MUTE_CTRL && wb_dat_in[BLK0_DIS_BIT]);
	cover property (tk && !wb_we_in && ix == IDX_RATIO_BASE);
endmodule
bind arr_regs arr_regs_props u_chk (.*);
`default_nettype wire

// File: testbench/tb_arr_regs.sv
// Purpose: self-checking bench for arr_regs
// Assumes: clock enable high except one freeze test
// Notes: reads are scored by a monitor against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tb_arr_regs
	import arr_pkg::*;
;
	logic clk;
	logic rst_b = 1'b0;
	logic en = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [31:0] adr = '0;
	logic [31:0] di = '0;
	logic [31:0] dq;
	logic ack;
	arr_rate_s [NUM_CONV-1:0] rt;
	arr_conv_ctrl_s [NUM_CONV-1:0] ct;
	logic [31:0] eq[$];
	logic [31:0] r = 32'hd3a9;
	logic [15:0] lim[NUM_CONV];
	int mismatches = 0;
	int checks_done = 0;
	int ticks = 0;
	arr_regs u_dut (.ref_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(en), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h3), .wb_dat_in(di),
		.wb_dat_out(dq), .wb_ack_out(ack), .conv_rates_in(rt), .conv_ctrl_out(ct));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// floor of in*4096/out, clipped; zero divisor reads zero
	function automatic logic [15:0] rat(input arr_rate_s v);
		logic [63:0] q;
		q = (v.out_rate == '0) ? 64'h0 : ({44'h0, v.in_rate} << FRAC_BITS) / v.out_rate;
		return (q > 64'hffff) ? 16'hffff : q[15:0];
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [15:0] ix, input logic [15:0] d, input logic [15:0] e);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {14'h0, ix, 2'b00};
		di <= {16'h0, d};
		if (!w) eq.push_back({16'h0, e});
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic ctl(input logic [7:0] m, input logic ov, input logic [10:0] v);
		for (int i = 0; i < NUM_CONV; i++) chk({20'h0, ct[i]}, {20'h0, m[i], ov ? v : lim[i][10:0]});
	endtask
	always @(posedge clk) begin
		ticks++;
		if (ticks == 5000) begin
			mismatches++;
			wrap_up();
		end
		if (ack === 1'b1 && we === 1'b0) chk(dq, eq.pop_front());
	end
	initial begin
		for (int i = 0; i < NUM_CONV; i++) begin
			r = lfsr(r);
			rt[i] = {r[19:0], 1'b0, r[31:20], 7'h01};
			lim[i] = LIMIT_RESET;
		end
		rt[1] = {20'd48000, 20'd48000};
		rt[2] = {20'd96000, 20'd48000};
		rt[3] = {20'd24000, 20'd48000};
		rt[4] = {20'd5, 20'd0};
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		wb(1'b0, IDX_OVR, 16'h0, OVR_RESET);
		wb(1'b0, IDX_MUTE_CTRL, 16'h0, MUTE_RESET);
		for (int i = 0; i < NUM_CONV; i++) wb(1'b0, IDX_LIMIT_BASE + 16'(i), 16'h0, LIMIT_RESET);
		ctl(8'h00, 1'b0, 11'h0);
		$display("reset test done");
		// a full round robin pass of the divider
		repeat (300) @(posedge clk);
		for (int i = 0; i < NUM_CONV; i++) wb(1'b0, IDX_RATIO_BASE + 16'(i), 16'h0, rat(rt[i]));
		wb(1'b1, IDX_RATIO_BASE, 16'h5a5a, 16'h0);
		wb(1'b0, IDX_RATIO_BASE, 16'h0, rat(rt[0]));
		$display("ratio test done");
		for (int i = 0; i < NUM_CONV; i++) begin
			r = lfsr(r);
			lim[i] = r[15:0];
			wb(1'b1, IDX_LIMIT_BASE + 16'(i), lim[i], 16'h0);
			wb(1'b0, IDX_LIMIT_BASE + 16'(i), 16'h0, lim[i] & LIMIT_MASK);
		end
		ctl(8'h00, 1'b0, 11'h0);
		r = lfsr(r);
		wb(1'b1, IDX_OVR, {5'h1f, r[10:0]}, 16'h0);
		wb(1'b0, IDX_OVR, 16'h0, {5'h01, r[10:0]});
		ctl(8'h00, 1'b1, r[10:0]);
		wb(1'b1, IDX_OVR, 16'h0, 16'h0);
		ctl(8'h00, 1'b0, 11'h0);
		$display("ramp limit test done");
		wb(1'b1, IDX_MUTE_CTRL, 16'h00ff, 16'h0);
		ctl(8'hff, 1'b0, 11'h0);
		wb(1'b1, IDX_MUTE_CTRL, 16'h01ff, 16'h0);
		ctl(8'hf0, 1'b0, 11'h0);
		wb(1'b1, IDX_MUTE_CTRL, 16'h02a5, 16'h0);
		ctl(8'h05, 1'b0, 11'h0);
		wb(1'b0, IDX_MUTE_CTRL, 16'h0, 16'h02a5);
		wb(1'b1, IDX_MUTE_CTRL, 16'h0000, 16'h0);
		ctl(8'h00, 1'b0, 11'h0);
		// frozen clock enable: request must wait, no ack
		en <= 1'b0;
		fork
			wb(1'b0, IDX_MUTE_CTRL, 16'h0, MUTE_RESET);
			begin
				repeat (4) @(posedge clk);
				chk({31'h0, ack}, 32'h0);
				en <= 1'b1;
			end
		join
		wb(1'b0, 16'h1234, 16'h0, 16'h0);
		$display("mute and unmapped test done");
		wrap_up();
	end
endmodule
`default_nettype wire
